// *** src/tcal_alarm_logic.sv ***
/*
 * tcal_alarm_logic: conversion sequencer, result store, limit compare,
 * fault queue and two open-drain alarm outputs, with a byte register port.
 * Assumes adc_sample is driven by modulator logic on ref_clk, and that the
 * register port runs on the serial clock, which may stop between frames.
 */
`default_nettype none

module tcal_alarm_logic #(
    parameter int unsigned CONV_CYC     = tcal_pkg::CONV_MS * tcal_pkg::CLK_KHZ,
    parameter int unsigned FAST_CYC     = tcal_pkg::FAST_MS * tcal_pkg::CLK_KHZ,
    parameter int unsigned SPS_CONV_CYC = tcal_pkg::SPS_CONV_MS * tcal_pkg::CLK_KHZ,
    parameter int unsigned SPS_IDLE_CYC = tcal_pkg::SPS_IDLE_MS * tcal_pkg::CLK_KHZ,
    parameter int unsigned WAKE_CYC     = tcal_pkg::WAKE_MS * tcal_pkg::CLK_KHZ,
    parameter logic [7:0]  ID_CODE      = 8'h5a // Arbitrary identification value
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] adc_sample,
    input  wire logic        link_clk,
    input  wire logic        link_rst_n,
    input  wire logic        link_req,
    input  wire logic [1:0]  link_op,
    input  wire logic [7:0]  link_data,
    output logic             link_busy,
    output logic [7:0]       link_rdata,
    output logic             critical_alarm_out_out,
    output logic             critical_alarm_out_oe,
    output logic             limit_alarm_out_out,
    output logic             limit_alarm_out_oe
);
    logic                   req_tgl;
    logic [1:0]             hold_op;
    logic [7:0]             hold_data;
    logic                   ack_s1;
    logic                   ack_s2;
    logic                   ack_s3;
    logic                   req_s1;
    logic                   req_s2;
    logic                   req_s3;
    logic                   ack_tgl;
    logic [7:0]             rd_hold;
    logic [7:0]             rd_mux;
    logic                   op_go;
    logic                   reg_wr;
    logic                   reg_rd;
    logic                   mode_wr;
    tcal_pkg::tcal_mode_e   new_mode;
    tcal_pkg::tcal_mode_e   mode;
    logic [7:0]             ptr;
    logic [7:0]             cfg;
    logic [15:0]            lim_high;
    logic [15:0]            lim_low;
    logic [15:0]            lim_crit;
    logic [7:0]             hyst;
    logic [15:0]            temp_result;
    logic [2:0]             flags;
    tcal_pkg::tcal_state_e  st;
    logic [31:0]            tmr;
    logic                   hard_shut;
    logic                   conv_done;
    logic [15:0]            t16;
    logic [15:0]            next_result;
    logic signed [16:0]     t_cmp;
    logic signed [16:0]     hy_s;
    logic                   high_f;
    logic                   low_f;
    logic [1:0]             fault;
    logic [1:0]             rel;
    logic [1:0]             pol;
    logic [1:0]             qual;
    logic [1:0]             alarm_v;
    logic [1:0]             oe_v;
    logic [2:0]             qlen;

    // Link side: hold the request until the far side acknowledges it
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            req_tgl   <= 1'b0;
            hold_op   <= 2'b00;
            hold_data <= 8'h00;
        end else if (link_req && !link_busy) begin
            req_tgl   <= ~req_tgl;
            hold_op   <= link_op;
            hold_data <= link_data;
        end
    end

    // Acknowledge synchroniser; the third stage only feeds edge detection
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_s3 <= 1'b0;
        end else begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
        end
    end

    assign link_busy = req_tgl ^ ack_s2;

    // Read data is stable in rd_hold long before the acknowledge lands
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            link_rdata <= 8'h00;
        end else if ((ack_s2 ^ ack_s3) && hold_op == tcal_pkg::OP_RD) begin
            link_rdata <= rd_hold;
        end
    end

    // Request synchroniser into the conversion domain
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end

    assign op_go    = req_s2 ^ req_s3;
    assign reg_wr   = op_go && hold_op == tcal_pkg::OP_WR;
    assign reg_rd   = op_go && hold_op == tcal_pkg::OP_RD;
    assign mode_wr  = reg_wr && ptr == tcal_pkg::ADDR_CFG;
    assign new_mode = tcal_pkg::tcal_mode_e'(hold_data[tcal_pkg::CFG_MODE_LSB +: 2]);
    assign mode     = tcal_pkg::tcal_mode_e'(cfg[tcal_pkg::CFG_MODE_LSB +: 2]);

    // Pointer loads on a pointer op and steps after each data byte
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ptr <= tcal_pkg::RST_PTR;
        end else if (op_go && hold_op == tcal_pkg::OP_PTR) begin
            ptr <= hold_data;
        end else if (reg_wr || reg_rd) begin
            ptr <= ptr + 8'h01;
        end
    end

    // Acknowledge and read capture
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_tgl <= 1'b0;
            rd_hold <= 8'h00;
        end else if (op_go) begin
            ack_tgl <= ~ack_tgl;
            rd_hold <= reg_rd ? rd_mux : rd_hold;
        end
    end

    // Writable registers; read-only addresses ignore writes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg      <= tcal_pkg::RST_CFG;
            lim_high <= tcal_pkg::RST_HIGH;
            lim_low  <= tcal_pkg::RST_LOW;
            lim_crit <= tcal_pkg::RST_CRIT;
            hyst     <= tcal_pkg::RST_HYST;
        end else if (reg_wr) begin
            unique case (ptr)
                tcal_pkg::ADDR_CFG:      cfg            <= hold_data;
                tcal_pkg::ADDR_HIGH_MSB: lim_high[15:8] <= hold_data;
                tcal_pkg::ADDR_HIGH_LSB: lim_high[7:0]  <= hold_data;
                tcal_pkg::ADDR_LOW_MSB:  lim_low[15:8]  <= hold_data;
                tcal_pkg::ADDR_LOW_LSB:  lim_low[7:0]   <= hold_data;
                tcal_pkg::ADDR_CRIT_MSB: lim_crit[15:8] <= hold_data;
                tcal_pkg::ADDR_CRIT_LSB: lim_crit[7:0]  <= hold_data;
                tcal_pkg::ADDR_HYST:     hyst           <= hold_data;
                default:                 cfg            <= cfg;
            endcase
        end
    end

    // Read selection; unmapped addresses read zero
    always_comb begin
        unique case (ptr)
            tcal_pkg::ADDR_TEMP_MSB: rd_mux = temp_result[15:8];
            tcal_pkg::ADDR_TEMP_LSB: rd_mux = temp_result[7:0];
            tcal_pkg::ADDR_STATUS:   rd_mux = {1'b0, flags, 4'h0};
            tcal_pkg::ADDR_CFG:      rd_mux = cfg;
            tcal_pkg::ADDR_HIGH_MSB: rd_mux = lim_high[15:8];
            tcal_pkg::ADDR_HIGH_LSB: rd_mux = lim_high[7:0];
            tcal_pkg::ADDR_LOW_MSB:  rd_mux = lim_low[15:8];
            tcal_pkg::ADDR_LOW_LSB:  rd_mux = lim_low[7:0];
            tcal_pkg::ADDR_CRIT_MSB: rd_mux = lim_crit[15:8];
            tcal_pkg::ADDR_CRIT_LSB: rd_mux = lim_crit[7:0];
            tcal_pkg::ADDR_HYST:     rd_mux = hyst;
            tcal_pkg::ADDR_ID:       rd_mux = ID_CODE;
            default:                 rd_mux = 8'h00;
        endcase
    end

    // Sequencer; a shutdown mode write overrides whatever timing is in progress, a single-shot or SPS write only while no shutdown write holds
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st        <= tcal_pkg::ST_FAST;
            tmr       <= 32'(FAST_CYC - 1);
            hard_shut <= 1'b0;
        end else if (mode_wr) begin
            unique case (new_mode)
                tcal_pkg::MODE_SHUT: begin
                    st        <= tcal_pkg::ST_SHUT;
                    hard_shut <= 1'b1;
                end
                tcal_pkg::MODE_SINGLE: begin
                    if (!hard_shut) begin
                        st  <= tcal_pkg::ST_CONV;
                        tmr <= 32'(CONV_CYC - 1);
                    end
                end
                tcal_pkg::MODE_SPS: begin
                    if (!hard_shut) begin
                        st  <= tcal_pkg::ST_CONV;
                        tmr <= 32'(SPS_CONV_CYC - 1);
                    end
                end
                tcal_pkg::MODE_CONT: begin
                    if (st == tcal_pkg::ST_SHUT) begin
                        st        <= tcal_pkg::ST_WAKE;
                        tmr       <= 32'(WAKE_CYC - 1);
                        hard_shut <= 1'b0;
                    end
                end
            endcase
        end else if (tmr != 32'h0) begin
            tmr <= tmr - 32'h1;
        end else begin
            unique case (st)
                tcal_pkg::ST_FAST, tcal_pkg::ST_CONV: begin
                    if (mode == tcal_pkg::MODE_SPS) begin
                        st  <= tcal_pkg::ST_IDLE;
                        tmr <= 32'(SPS_IDLE_CYC - 1);
                    end else if (mode == tcal_pkg::MODE_CONT) begin
                        st  <= tcal_pkg::ST_CONV;
                        tmr <= 32'(CONV_CYC - 1);
                    end else begin
                        st <= tcal_pkg::ST_SHUT;
                    end
                end
                tcal_pkg::ST_IDLE: begin
                    st  <= tcal_pkg::ST_CONV;
                    tmr <= (mode == tcal_pkg::MODE_SPS) ? 32'(SPS_CONV_CYC - 1)
                                                        : 32'(CONV_CYC - 1);
                end
                tcal_pkg::ST_WAKE: begin
                    st  <= tcal_pkg::ST_CONV;
                    tmr <= 32'(CONV_CYC - 1);
                end
                tcal_pkg::ST_SHUT: st <= tcal_pkg::ST_SHUT;
                default:           st <= tcal_pkg::ST_SHUT;
            endcase
        end
    end

    // A conversion aborted by a mode write in its last cycle yields nothing
    assign conv_done = (st == tcal_pkg::ST_FAST || st == tcal_pkg::ST_CONV)
                       && tmr == 32'h0 && !mode_wr;

    // Compare value drops the low three bits in 13-bit resolution
    assign t16    = cfg[tcal_pkg::CFG_RES] ? adc_sample : {adc_sample[15:3], 3'h0};
    assign t_cmp  = {t16[15], t16};
    assign hy_s   = {6'h00, hyst[3:0], 7'h00}; // Whole degrees, 4-bit range
    assign high_f = t_cmp > $signed({lim_high[15], lim_high});
    assign low_f  = t_cmp < $signed({lim_low[15], lim_low});
    assign fault  = {high_f || low_f, t_cmp > $signed({lim_crit[15], lim_crit})};
    assign rel[0] = t_cmp < ($signed({lim_crit[15], lim_crit}) - hy_s);
    assign rel[1] = (t_cmp < ($signed({lim_high[15], lim_high}) - hy_s))
                    && (t_cmp > ($signed({lim_low[15], lim_low}) + hy_s));
    assign pol    = {cfg[tcal_pkg::CFG_INT_POL], cfg[tcal_pkg::CFG_CT_POL]};
    assign qlen   = {1'b0, cfg[tcal_pkg::CFG_QUEUE_LSB +: 2]} + 3'h1;
    assign next_result = cfg[tcal_pkg::CFG_RES] ? adc_sample
                         : {adc_sample[15:3], fault[0], high_f, low_f};

    // Result store; held untouched through shutdown
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            temp_result <= tcal_pkg::RST_TEMP;
            flags       <= 3'h0;
        end else if (conv_done) begin
            temp_result <= next_result;
            flags       <= {fault[0], high_f, low_f};
        end
    end

    // Index 0 is the critical alarm, index 1 the limit alarm
    for (genvar i = 0; i < 2; i++) begin : g_alarm
        logic [2:0] fcnt;
        logic       act;
        logic       pend;
        logic       oe;

        assign qual[i] = fault[i] && ((fcnt + 3'h1) >= qlen);

        // Consecutive-fault count, updated only when a conversion lands
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                fcnt <= 3'h0;
            end else if (conv_done) begin
                fcnt <= !fault[i] ? 3'h0 : (qual[i] ? qlen : fcnt + 3'h1);
            end
        end

        // A qualified fault wins over any clear in the same cycle
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                act  <= 1'b0;
                pend <= 1'b0;
            end else if (conv_done && qual[i]) begin
                act  <= 1'b1;
                pend <= 1'b0;
            end else if (cfg[tcal_pkg::CFG_INTR]) begin
                pend <= 1'b0;
                if (reg_rd) begin
                    act <= 1'b0;
                end
            end else if (conv_done && rel[i] && act) begin
                if (mode == tcal_pkg::MODE_SINGLE) begin
                    pend <= 1'b1;
                end else begin
                    act <= 1'b0;
                end
            end else if (mode_wr && pend) begin
                act  <= 1'b0;
                pend <= 1'b0;
            end
        end

        // Open drain pulls low when the level to show is low
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                oe <= 1'b0;
            end else begin
                oe <= act ^ pol[i];
            end
        end

        assign alarm_v[i] = act;
        assign oe_v[i]    = oe;
    end

    assign critical_alarm_out_out = 1'b0;
    assign limit_alarm_out_out    = 1'b0;
    assign critical_alarm_out_oe  = oe_v[0];
    assign limit_alarm_out_oe     = oe_v[1];

    // Checks beside the sequencer and alarms
    property p_cont_chain;
        @(posedge ref_clk) disable iff (!rst_n)
        (conv_done && mode == tcal_pkg::MODE_CONT)
        |=> (st == tcal_pkg::ST_CONV && tmr == 32'(CONV_CYC - 1));
    endproperty
    a_cont_chain: assert property (p_cont_chain) else $error("no back to back conversion");

    property p_store;
        @(posedge ref_clk) disable iff (!rst_n)
        conv_done |=> temp_result == $past(next_result);
    endproperty
    a_store: assert property (p_store) else $error("result not stored");

    property p_fast_end;
        @(posedge ref_clk) disable iff (!rst_n)
        (st == tcal_pkg::ST_FAST && tmr == 32'h0 && !mode_wr && mode == tcal_pkg::MODE_CONT)
        |=> st == tcal_pkg::ST_CONV;
    endproperty
    a_fast_end: assert property (p_fast_end) else $error("fast conversion not followed");

    property p_crit_set;
        @(posedge ref_clk) disable iff (!rst_n)
        (conv_done && qual[0]) |=> alarm_v[0] ##1 (critical_alarm_out_oe != pol[0]);
    endproperty
    a_crit_set: assert property (p_crit_set) else $error("critical alarm missed");

    property p_single_off;
        @(posedge ref_clk) disable iff (!rst_n)
        (conv_done && mode == tcal_pkg::MODE_SINGLE) |=> st == tcal_pkg::ST_SHUT;
    endproperty
    a_single_off: assert property (p_single_off) else $error("single shot kept running");

    property p_sps_idle;
        @(posedge ref_clk) disable iff (!rst_n)
        (conv_done && mode == tcal_pkg::MODE_SPS)
        |=> (st == tcal_pkg::ST_IDLE && tmr == 32'(SPS_IDLE_CYC - 1));
    endproperty
    a_sps_idle: assert property (p_sps_idle) else $error("idle period wrong");

    property p_intr_clr;
        @(posedge ref_clk) disable iff (!rst_n)
        (cfg[tcal_pkg::CFG_INTR] && reg_rd && !conv_done) |=> alarm_v == 2'b00;
    endproperty
    a_intr_clr: assert property (p_intr_clr) else $error("read did not clear alarms");

    property p_shut_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (st == tcal_pkg::ST_SHUT && !mode_wr) |=> (st == tcal_pkg::ST_SHUT && $stable(temp_result));
    endproperty
    a_shut_hold: assert property (p_shut_hold) else $error("shutdown disturbed");

    property p_wake;
        @(posedge ref_clk) disable iff (!rst_n)
        (st == tcal_pkg::ST_SHUT && mode_wr && new_mode == tcal_pkg::MODE_CONT)
        |=> (st == tcal_pkg::ST_WAKE && tmr == 32'(WAKE_CYC - 1));
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up not started");

    property p_queue_clr;
        @(posedge ref_clk) disable iff (!rst_n)
        (conv_done && !fault[1] && !fault[0]) |=> (g_alarm[0].fcnt == 3'h0 && g_alarm[1].fcnt == 3'h0);
    endproperty
    a_queue_clr: assert property (p_queue_clr) else $error("fault count not cleared");

    property p_link_hold;
        @(posedge link_clk) disable iff (!link_rst_n)
        (link_req && !link_busy) |=> link_busy [*2];
    endproperty
    a_link_hold: assert property (p_link_hold) else $error("request not held");

    c_single: cover property (@(posedge ref_clk) disable iff (!rst_n)
        conv_done && mode == tcal_pkg::MODE_SINGLE);
    c_wake: cover property (@(posedge ref_clk) disable iff (!rst_n) st == tcal_pkg::ST_WAKE);
    c_crit: cover property (@(posedge ref_clk) disable iff (!rst_n) conv_done && qual[0]);
    c_intr: cover property (@(posedge ref_clk) disable iff (!rst_n)
        cfg[tcal_pkg::CFG_INTR] && reg_rd && alarm_v != 2'b00);
endmodule // tcal_alarm_logic

`default_nettype wire

// *** pkg/tcal_pkg.sv ***
/*
 * tcal_pkg: constants and types for the temperature conversion and alarm block.
 * Assumes a 100 MHz reference clock and a byte-wide register access port.
 */
`default_nettype none

package tcal_pkg;
    // Clock rate in kilohertz and documented times in milliseconds
    localparam int unsigned CLK_KHZ     = 100000;
    localparam int unsigned CONV_MS     = 240;
    localparam int unsigned FAST_MS     = 6;
    localparam int unsigned SPS_CONV_MS = 60;
    localparam int unsigned SPS_IDLE_MS = 940;
    localparam int unsigned WAKE_MS     = 1;

    // Register addresses as seen through the pointer
    localparam logic [7:0] ADDR_TEMP_MSB = 8'h00;
    localparam logic [7:0] ADDR_TEMP_LSB = 8'h01;
    localparam logic [7:0] ADDR_STATUS   = 8'h02;
    localparam logic [7:0] ADDR_CFG      = 8'h03;
    localparam logic [7:0] ADDR_HIGH_MSB = 8'h04;
    localparam logic [7:0] ADDR_HIGH_LSB = 8'h05;
    localparam logic [7:0] ADDR_LOW_MSB  = 8'h06;
    localparam logic [7:0] ADDR_LOW_LSB  = 8'h07;
    localparam logic [7:0] ADDR_CRIT_MSB = 8'h08;
    localparam logic [7:0] ADDR_CRIT_LSB = 8'h09;
    localparam logic [7:0] ADDR_HYST     = 8'h0a;
    localparam logic [7:0] ADDR_ID       = 8'h0b;

    // Reset values
    localparam logic [7:0]  RST_PTR  = 8'h00;
    localparam logic [7:0]  RST_CFG  = 8'h00;
    localparam logic [15:0] RST_TEMP = 16'h0000;
    localparam logic [15:0] RST_HIGH = 16'h2000;
    localparam logic [15:0] RST_LOW  = 16'h0500;
    localparam logic [15:0] RST_CRIT = 16'h4980;
    localparam logic [7:0]  RST_HYST = 8'h05;

    // Field positions in the measurement_control register
    localparam int CFG_QUEUE_LSB = 0;
    localparam int CFG_CT_POL    = 2;
    localparam int CFG_INT_POL   = 3;
    localparam int CFG_INTR      = 4;
    localparam int CFG_MODE_LSB  = 5;
    localparam int CFG_RES       = 7;

    // Field positions in the status register
    localparam int STAT_CRIT = 6;
    localparam int STAT_HIGH = 5;
    localparam int STAT_LOW  = 4;

    typedef enum logic [1:0] {
        MODE_CONT   = 2'b00,
        MODE_SINGLE = 2'b01,
        MODE_SPS    = 2'b10,
        MODE_SHUT   = 2'b11
    } tcal_mode_e;

    typedef enum logic [1:0] {
        OP_PTR = 2'b00,
        OP_WR  = 2'b01,
        OP_RD  = 2'b10
    } tcal_op_e;

    typedef enum logic [2:0] {
        ST_FAST = 3'b000,
        ST_CONV = 3'b001,
        ST_IDLE = 3'b010,
        ST_SHUT = 3'b011,
        ST_WAKE = 3'b100
    } tcal_state_e;
endpackage

`default_nettype wire

// *** bench/tcal_host_model.sv ***
/* Serial host model driving the byte register port.
   Assumes the bench calls xfer; link clock stops between transfers. */
`default_nettype none
module tcal_host_model (
    output logic       link_clk,
    output logic       link_rst_n,
    output logic       link_req,
    output logic [1:0] link_op,
    output logic [7:0] link_data,
    input  wire logic  link_busy,
    input  wire logic [7:0] link_rdata,
    output logic       rd_done,
    output logic [7:0] rd_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run = 1'b1;
    // Gated 30 ns clock, odd phase against ref_clk
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = run & ~link_clk;
    end
    // Link reset needs a running clock
    initial begin
        {link_rst_n, link_req, link_op, link_data, rd_done, rd_byte} = '0;
        repeat (4) @(posedge link_clk);
        #1 link_rst_n = 1'b1;
        run = 1'b0;
    end
    // One strobe, then hold until busy drops
    task automatic xfer(input logic [1:0] op, input logic [7:0] d);
        int n;
        n = 0;
        run = 1'b1;
        @(posedge link_clk);
        #1 {link_req, link_op, link_data} = {1'b1, op, d};
        @(posedge link_clk);
        #1 link_req = 1'b0;
        link_data = ~d; // Released lines show no stale value
        @(posedge link_clk);
        #1;
        while (link_busy !== 1'b0 && n < 20) begin
            @(posedge link_clk);
            #1 n++;
        end
        if (n >= 20) tb_top.failures++; // A hung handshake counts as a mismatch
        // Read byte is loaded one link edge after busy falls
        @(posedge link_clk);
        #1 rd_byte = link_rdata;
        rd_done = (op == 2'b10);
        @(posedge link_clk);
        #1 rd_done = 1'b0;
        run = 1'b0;
    endtask
endmodule // tcal_host_model
`default_nettype wire

// *** bench/tb_top.sv ***
/* Self-checking bench for tcal_alarm_logic.
   Assumes small timing parameters; the host model owns the link clock. */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CV = 40;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] adc = 16'h0a00;
    logic lclk, lrst_n, req, busy, c_oe, l_oe, c_q, l_q, rd_done;
    logic [1:0] op;
    logic [7:0] wd, rdata, rd_byte;
    logic [31:0] lfsr = 32'h679617aa;
    logic [7:0] exp_q[$];
    logic [7:0] tab[8] = '{8'h00, 8'h20, 8'h00, 8'h05, 8'h00, 8'h49, 8'h80, 8'h05};
    int failures = 0;
    int tests_run = 0;
    always #5 ref_clk = ~ref_clk;
    tcal_alarm_logic #(.CONV_CYC(CV), .FAST_CYC(8), .SPS_CONV_CYC(20),
        .SPS_IDLE_CYC(30), .WAKE_CYC(5), .ID_CODE(8'h3c)) // Arbitrary identity value
        uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .adc_sample(adc), .link_clk(lclk), .link_rst_n(lrst_n), .link_req(req),
        .link_op(op), .link_data(wd), .link_busy(busy), .link_rdata(rdata),
        .critical_alarm_out_out(c_q), .critical_alarm_out_oe(c_oe),
        .limit_alarm_out_out(l_q), .limit_alarm_out_oe(l_oe));
    tcal_host_model host (.link_clk(lclk), .link_rst_n(lrst_n), .link_req(req),
        .link_op(op), .link_data(wd), .link_busy(busy), .link_rdata(rdata),
        .rd_done(rd_done), .rd_byte(rd_byte));
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Random source for sample values
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic end_sim;
        if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic sa(input logic [15:0] v);
        wc(1);
        adc = v;
    endtask
    task automatic rd(input logic [7:0] e);
        exp_q.push_back(e);
        host.xfer(2'b10, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(2'b00, a);
        host.xfer(2'b01, d);
    endtask
    // Monitor takes the oldest note per read
    always @(posedge rd_done) check(rd_byte, exp_q.pop_front());
    initial begin
        #100us failures++;
        end_sim;
    end
    // Main sequence
    initial begin
        wc(4);
        rst_n = 1'b1;
        wc(10);
        rd(8'h0a);
        host.xfer(2'b00, 8'h03);
        foreach (tab[i]) rd(tab[i]);
        host.xfer(2'b00, 8'h20);
        rd(8'h00);
        for (int i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            sa({4'h1, lfsr[11:0]});
            wc(CV + 10);
            host.xfer(2'b00, 8'h00);
            rd(adc[15:8]);
            check({6'h00, c_oe, l_oe}, 8'h00);
        end
        sa(16'h3000);
        wc(CV + 10);
        check({6'h00, c_oe, l_oe}, 8'h01);
        sa(16'h5000);
        wc(CV + 10);
        check({6'h00, c_oe, l_oe}, 8'h03);
        wr(8'h03, 8'h0c);
        wc(4);
        check({6'h00, c_oe, l_oe}, 8'h00);
        wr(8'h03, 8'h60);
        sa(16'h1234);
        wc(3 * CV);
        host.xfer(2'b00, 8'h00);
        rd(8'h50);
        wr(8'h03, 8'h00);
        wc(CV + 20);
        host.xfer(2'b00, 8'h00);
        rd(8'h12);
        for (int i = 0; i < 2; i++) begin
            sa(16'(16'h1100 + 16'h0400 * i));
            wr(8'h03, 8'h20);
            wc(CV + 10);
            host.xfer(2'b00, 8'h00);
            rd(8'(8'h11 + 8'h04 * i));
            sa(16'h1900);
            wc(3 * CV);
            host.xfer(2'b00, 8'h00);
            rd(8'(8'h11 + 8'h04 * i));
        end
        // Once per second, interrupt mode, queue of two
        sa(16'h3000);
        wr(8'h03, 8'h51);
        wc(30);
        check({6'h00, c_oe, l_oe}, 8'h00);
        wc(50);
        check({6'h00, c_oe, l_oe}, 8'h01);
        sa(16'h1000);
        wc(50);
        check({6'h00, c_oe, l_oe}, 8'h01);
        host.xfer(2'b00, 8'h0b);
        rd(8'h3c);
        wc(2);
        check({6'h00, c_oe, l_oe}, 8'h00);
        // High resolution keeps the low bits as data
        sa(16'h1237);
        wr(8'h03, 8'h80);
        wc(100);
        host.xfer(2'b00, 8'h00);
        rd(8'h12);
        rd(8'h37);
        // Comparator single shot: release waits for a mode write
        wr(8'h03, 8'h20);
        sa(16'h5000);
        wc(4);
        check({6'h00, c_oe, l_oe}, 8'h00);
        wc(50);
        check({4'h0, c_q, l_q, c_oe, l_oe}, 8'h03);
        sa(16'h1000);
        wr(8'h03, 8'h20);
        wc(50);
        check({6'h00, c_oe, l_oe}, 8'h03);
        wr(8'h03, 8'h20);
        wc(4);
        check({6'h00, c_oe, l_oe}, 8'h00);
        check(8'(exp_q.size()), 8'h00);
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
